// ### verification/nfc_flash_model.sv
`timescale 1ns/1ps
// ==========================================================
// behavioural flash device, clockless, reacts to pin edges
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter logic [7:0] STATUS_BYTE = 8'he0
) (
  pins,
  busy_ns,
  bus,
  ready_busy_n
);
  input wire nfc_pins_t pins;
  input wire logic [31:0] busy_ns;
  output logic [7:0] bus;
  output logic ready_busy_n;
  logic [7:0] dout, last, cmd;
  logic [12:0] col;
  logic [1:0] mode;
  logic drv;
  int acnt, gen, k;
  logic [7:0] wr_seen[$];
  initial begin
    ready_busy_n = 1'b1; mode = 2'd0; col = '0; drv = 1'b0;
    last = 8'h00; acnt = 0; gen = 0; k = 0;
  end
  // busy low for the given time, newest wins
  task automatic go_busy(input int d);
    int g;
    gen++;
    g = gen;
    ready_busy_n = 1'b0;
    fork
      begin
        #(d);
        if (g == gen) ready_busy_n = 1'b1;
      end
    join_none
  endtask : go_busy
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    if (pins.cle) begin
      cmd = pins.io_out;
      acnt = 0;
      // only reset and status while busy
      if (ready_busy_n || cmd inside {8'hff, 8'h70, 8'h71}) case (cmd)
        8'h70, 8'h71: mode = 2'd1;
        8'h7a: begin mode = 2'd2; k = 0; end
        8'h30: begin mode = 2'd3; go_busy(busy_ns); end
        8'h10, 8'hd0, 8'hff: begin mode = 2'd0; go_busy(busy_ns); end
        8'h11: go_busy(500); // short gap busy
        default: mode = 2'd0;
      endcase
    end else if (pins.ale) begin
      if (acnt == 0) col[7:0] = pins.io_out;
      if (acnt == 1) col[12:8] = pins.io_out[4:0];
      acnt++;
    end else if (pins.io_oe) wr_seen.push_back(pins.io_out);
  end
  // a strobe fall presents a byte in status, ecc and read modes; only read mode moves the column
  always @(negedge pins.output_strobe_n) if (!pins.ce_n) begin
    drv = 1'b1;
    case (mode)
      2'd1: dout = STATUS_BYTE;
      2'd2: begin dout = 8'(8'h10 + k); k++; end
      2'd3: begin dout = col[7:0] ^ 8'h5a; col++; end
      default: drv = 1'b0;
    endcase
  end
  // drivers off on strobe rise, or cle, ale, ce rise or we fall
  // released bus shows inverse of last byte so a late sample is caught
  always @(posedge pins.output_strobe_n or posedge pins.ce_n or posedge pins.cle
    or posedge pins.ale or negedge pins.we_n) begin
    if (drv) last = dout;
    drv = 1'b0;
  end
  assign bus = pins.io_oe ? pins.io_out : (drv ? dout : ~last);
endmodule : nfc_flash_model

// ### verification/nfc_host_chk.sv
`timescale 1ns/1ps
// ==========================================================
// pin and handshake checker for the flash host
module nfc_host_chk
  import nfc_pkg::*;
#(
  parameter logic [15:0] PROG_MAX_CYC = 16'd7000,
  parameter logic [15:0] MRD_MAX_CYC = 16'd4200,
  parameter logic [15:0] RST_ERASE_CYC = 16'd5000,
  parameter logic [15:0] ERASE_MAX_CYC = 16'd50000
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire nfc_req_t req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire nfc_resp_t resp,
  input wire logic resp_valid,
  input wire nfc_pins_t pins,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // strobe shapes
  sequence s_we_pulse;
    !pins.we_n ##1 pins.we_n;
  endsequence
  sequence s_strobe_tail;
    !pins.output_strobe_n [*2] ##1 pins.output_strobe_n;
  endsequence
  a_no_drive_read: assert property (!pins.output_strobe_n |-> !pins.io_oe)
    else $error("host drives bus during output strobe");
  a_cmd_driven: assert property (pins.cle && !pins.we_n |-> pins.io_oe && !pins.ale && !pins.ce_n)
    else $error("command cycle not driven");
  a_we_one_low: assert property ($fell(pins.we_n) |-> s_we_pulse)
    else $error("write strobe width wrong");
  a_wr_byte_out: assert property (wr_valid && wr_ready |=> (!pins.we_n && pins.io_oe
    && pins.io_out == $past(wr_data)) ##1 pins.we_n)
    else $error("program byte not written");
  a_strobe_three: assert property ($fell(pins.output_strobe_n) |=> s_strobe_tail)
    else $error("output strobe width wrong");
  a_refuse_quiet: assert property (resp_valid && resp.refused |-> $past(pins.ce_n, 1)
    && $past(pins.ce_n, 2) && $past(pins.ce_n, 3))
    else $error("refused request touched pins");
  a_req_single: assert property (req_valid && req_ready |=> !req_ready until resp_valid)
    else $error("request port reopened early");
  a_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("response pulse too long");
  a_ce_released: assert property (resp_valid |-> pins.ce_n && !pins.io_oe)
    else $error("chip still selected at answer");
endmodule : nfc_host_chk
bind nfc_host nfc_host_chk #(.PROG_MAX_CYC(PROG_MAX_CYC), .MRD_MAX_CYC(MRD_MAX_CYC),
  .RST_ERASE_CYC(RST_ERASE_CYC), .ERASE_MAX_CYC(ERASE_MAX_CYC)) i_nfc_host_chk (
  .mclk(mclk), .resetn(resetn), .req(req), .req_valid(req_valid), .req_ready(req_ready),
  .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
  .rd_valid(rd_valid), .rd_ready(rd_ready), .resp(resp), .resp_valid(resp_valid),
  .pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));

// ### verification/nfc_host_tb.sv
`timescale 1ns/1ps
module nfc_host_tb
  import nfc_pkg::*;
;
  localparam logic [7:0] ST = 8'he0;
  logic mclk = 0, resetn = 0, req_valid = 0, wr_valid = 0, rd_ready = 1;
  nfc_req_t req = '0;
  logic [7:0] wr_data = 8'h00;
  logic req_ready, wr_ready, rd_valid, resp_valid, ready_busy_n;
  logic [7:0] rd_data, io_in;
  nfc_resp_t resp, got;
  nfc_pins_t pins;
  logic [31:0] busy_ns = 32'd1000;
  logic [7:0] wr_q[$], rd_q[$];
  int miscompares = 0, check_count = 0;
  always #50 mclk = ~mclk;
  nfc_host #(.PROG_MAX_CYC(16'd40), .MRD_MAX_CYC(16'd30), .RST_ERASE_CYC(16'd30),
    .ERASE_MAX_CYC(16'd50)) i_nfc_host (.mclk(mclk), .resetn(resetn), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .resp(resp), .resp_valid(resp_valid), .pins(pins), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  nfc_flash_model #(.STATUS_BYTE(ST)) i_nfc_flash_model (.pins(pins), .busy_ns(busy_ns),
    .bus(io_in), .ready_busy_n(ready_busy_n));
  // ==========================================================
  // data feeders: drive on falling edge, account on rising edge
  always @(negedge mclk) begin
    wr_valid = wr_q.size() > 0;
    wr_data = wr_valid ? wr_q[0] : 8'h00;
  end
  always @(posedge mclk) begin
    if (wr_valid && wr_ready === 1'b1) wr_q.delete(0);
    if (rd_valid === 1'b1 && rd_ready) rd_q.push_back(rd_data);
  end
  task automatic report_and_stop;
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (e !== s) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask : chk
  // bounded wait step, a hang ends the run
  task automatic tick(inout int n);
    @(negedge mclk);
    n++;
    if (n > 20000) begin
      miscompares++;
      report_and_stop();
    end
  endtask : tick
  task automatic do_req(input nfc_op_t op, input logic [17:0] row, input logic [12:0] col,
    input logic [12:0] len);
    int n;
    n = 0;
    rd_q.delete();
    @(negedge mclk);
    req = {op, col, row, len};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) tick(n);
    @(negedge mclk);
    req_valid = 1'b0;
    while (resp_valid !== 1'b1) tick(n);
    got = resp;
    while (rd_valid === 1'b1 && rd_ready) tick(n);
  endtask : do_req
  task automatic chk_bytes(input logic [7:0] base, input logic [7:0] x, input int cnt);
    chk("byte count", cnt, rd_q.size());
    foreach (rd_q[i]) chk("read byte", 8'(base + i) ^ x, rd_q[i]);
  endtask : chk_bytes
  // ==========================================================
  // scenarios
  task automatic t_status;
    do_req(NFC_OP_STATUS, 18'h0, 13'h0, 13'h0);
    chk_bytes(ST, 8'h00, 1);
    do_req(NFC_OP_STATUS_M, 18'h0, 13'h0, 13'h0);
    chk("status last byte", ST, got.last_byte);
  endtask : t_status
  task automatic t_read_ecc;
    busy_ns = 32'd3000;
    do_req(NFC_OP_READ, 18'h5, 13'h1fe, 13'h4);
    chk_bytes(8'hfe, 8'h5a, 4);
    do_req(NFC_OP_ECC, 18'h0, 13'h0, 13'h0);
    chk("ecc after data refused", 1, got.refused);
    do_req(NFC_OP_READ, 18'h5, 13'h0, 13'h0);
    do_req(NFC_OP_ECC, 18'h0, 13'h0, 13'h0);
    chk_bytes(8'h10, 8'h00, 8);
    do_req(NFC_OP_ECC, 18'h0, 13'h0, 13'h0);
    chk("second ecc refused", 1, got.refused);
  endtask : t_read_ecc
  // fifo fills to eight while the reader stalls
  task automatic t_fifo;
    rd_ready = 1'b0;
    fork
      begin
        repeat (200) @(negedge mclk);
        chk("fifo holds data", 1, rd_valid);
        chk("strobe stalled", 1, pins.output_strobe_n);
        rd_ready = 1'b1;
      end
    join_none
    do_req(NFC_OP_READ, 18'h1, 13'h0, 13'hc);
    chk_bytes(8'h00, 8'h5a, 12);
  endtask : t_fifo
  task automatic t_prog;
    busy_ns = 32'd1000;
    i_nfc_flash_model.wr_seen.delete();
    wr_q = '{8'ha5, 8'h3c};
    for (int i = 0; i < 5; i++) begin
      do_req(NFC_OP_PROG, 18'h40, 13'h0, 13'(i == 0 ? 2 : 0));
      chk("partial program refusal", i == 4, got.refused);
    end
    chk("bytes programmed", 2, i_nfc_flash_model.wr_seen.size());
    chk("program byte", 8'h3c, i_nfc_flash_model.wr_seen[1]);
    busy_ns = 32'd2000;
    do_req(NFC_OP_ERASE, 18'h40, 13'h0, 13'h0);
    chk("erase ok", 0, got.timeout);
    do_req(NFC_OP_PROG, 18'h40, 13'h0, 13'h0);
    chk("program after erase", 0, got.refused);
    do_req(NFC_OP_PROG_FIRST, 18'h40, 13'h0, 13'h0);
    chk("mid confirm", 8'h11, i_nfc_flash_model.cmd);
    chk("mid busy ok", 0, got.timeout);
    do_req(NFC_OP_PROG_LAST, 18'h40, 13'h0, 13'h0);
    chk("final confirm", 8'h10, i_nfc_flash_model.cmd);
    chk("final busy ok", 0, got.timeout);
    chk("write protect off", 1, pins.wp_n);
  endtask : t_prog
  // busy limits and the reset limit that follows a read, program or erase timeout
  task automatic t_timeout;
    nfc_op_t ops[7] = '{NFC_OP_READ_M, NFC_OP_RESET, NFC_OP_PROG, NFC_OP_RESET,
      NFC_OP_ERASE, NFC_OP_RESET, NFC_OP_RESET};
    int bns[7] = '{5000, 8000, 6000, 8000, 6000, 2000, 1000};
    logic exp[7] = '{1, 1, 1, 0, 1, 0, 0};
    for (int i = 0; i < 7; i++) begin
      busy_ns = 32'(bns[i]);
      do_req(ops[i], 18'h80, 13'h0, 13'h0);
      chk("timeout flag", exp[i], got.timeout);
    end
  endtask : t_timeout
  initial begin
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    t_status();
    t_read_ecc();
    t_fifo();
    t_prog();
    t_timeout();
    report_and_stop();
  end
endmodule : nfc_host_tb

// ### verilog/nfc_fifo.sv
`timescale 1ns/1ps
module nfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic full_reg;
  logic empty_reg;
  wire push = in_valid && !full_reg;
  wire pop = out_ready && !empty_reg;
  // ==========================================================
  // occupancy; flags registered so ready and valid are flops
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = !full_reg;
  assign out_valid = !empty_reg;
  assign out_data = mem[rd_ptr_reg];
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end
    else
    begin
      wr_ptr_reg <= push ? AW'((wr_ptr_reg + 1) % DEPTH) : wr_ptr_reg;
      rd_ptr_reg <= pop ? AW'((rd_ptr_reg + 1) % DEPTH) : rd_ptr_reg;
      cnt_reg <= cnt_next;
      full_reg <= (cnt_next == (AW+1)'(DEPTH));
      empty_reg <= (cnt_next == '0);
    end
  end
  // storage needs no reset, only the pointers, count and flags do
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end
endmodule : nfc_fifo

// ### verilog/nfc_host.sv
`timescale 1ns/1ps
`include "nfc_regs.svh"
module nfc_host
  import nfc_pkg::*;
#(
  parameter logic [15:0] PROG_MAX_CYC = 16'(`NFC_PROG_MAX_CYC),
  parameter logic [15:0] MRD_MAX_CYC = 16'(`NFC_MRD_MAX_CYC),
  parameter logic [15:0] RST_ERASE_CYC = 16'(`NFC_RST_ERASE_CYC),
  parameter logic [15:0] ERASE_MAX_CYC = 16'(`NFC_ERASE_MAX_CYC)
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire nfc_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output nfc_resp_t resp,
  output logic resp_valid,
  output nfc_pins_t pins,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  localparam nfc_pins_t PINS_RST = '{ce_n: 1'b1, we_n: 1'b1, output_strobe_n: 1'b1,
    default: '0};
  localparam logic [15:0] WB_WAIT = 16'(`NFC_WB_CYC + 2);
  nfc_state_t state_reg, state_next;
  nfc_pins_t pins_reg, pins_next;
  nfc_req_t req_reg, req_next;
  nfc_resp_t resp_reg;
  logic [1:0] ph_reg, ph_next;
  logic [2:0] aidx_reg, aidx_next;
  logic [12:0] cnt_reg, cnt_next;
  logic [15:0] tmr_reg, tmr_next;
  logic tout_reg, tout_next, refd_reg, refd_next;
  logic [7:0] lastb_reg, lastb_next;
  logic req_ready_reg, wr_ready_reg, resp_valid_reg;
  logic rb_meta_reg, rb_sync_reg;
  logic [7:0] io_meta_reg, io_sync_reg;
  logic [17:0] pp_page_reg;
  logic [2:0] pp_cnt_reg;
  logic ecc_ok_reg;
  logic [1:0] hung_reg;
  logic take, push, fifo_in_ready;
  // ==========================================================
  // operation decode from the captured request
  wire nfc_op_t op = req_reg.op;
  wire is_rd = (op == NFC_OP_READ) || (op == NFC_OP_READ_M);
  wire is_pg = (op == NFC_OP_PROG) || (op == NFC_OP_PROG_FIRST) || (op == NFC_OP_PROG_LAST);
  wire is_er = (op == NFC_OP_ERASE);
  wire is_st = (op == NFC_OP_STATUS) || (op == NFC_OP_STATUS_M);
  wire [7:0] cmd1 = is_rd ? `NFC_CMD_READ1 : (op == NFC_OP_PROG_LAST) ? `NFC_CMD_PROGM1 :
    is_pg ? `NFC_CMD_PROG1 : is_er ? `NFC_CMD_ERASE1 : (op == NFC_OP_STATUS) ?
    `NFC_CMD_STATUS : (op == NFC_OP_STATUS_M) ? `NFC_CMD_STATUSM :
    (op == NFC_OP_ECC) ? `NFC_CMD_ECC : `NFC_CMD_RESET;
  wire [7:0] cmd2 = is_rd ? `NFC_CMD_READ2 : (op == NFC_OP_PROG_FIRST) ? `NFC_CMD_PROGMID :
    is_er ? `NFC_CMD_ERASE2 : `NFC_CMD_PROG2;
  wire [2:0] naddr = (is_rd || is_pg) ? `NFC_ADDR_FULL : is_er ? `NFC_ADDR_ROW : 3'h0;
  wire busy_op = is_rd || is_pg || is_er || (op == NFC_OP_RESET);
  wire [12:0] rd_n = is_rd ? req_reg.len : is_st ? 13'h001 :
    (op == NFC_OP_ECC) ? `NFC_ECC_BYTES : 13'h000;
  wire [12:0] wr_n = is_pg ? req_reg.len : 13'h000;
  // reset and status go out even while busy
  wire need_ready = busy_op && (op != NFC_OP_RESET);
  // reset limit follows what was left running
  wire [15:0] rst_lim = (hung_reg == 2'h2) ? RST_ERASE_CYC :
    (hung_reg == 2'h1) ? 16'(`NFC_RST_PROG_CYC) : 16'(`NFC_RST_IDLE_CYC);
  wire [15:0] limit = (op == NFC_OP_RESET) ? rst_lim :
    (op == NFC_OP_READ) ? 16'(`NFC_RD_MAX_CYC) : (op == NFC_OP_READ_M) ? MRD_MAX_CYC :
    (op == NFC_OP_PROG_FIRST) ? 16'(`NFC_DCBSY_MAX_CYC) : is_er ? ERASE_MAX_CYC : PROG_MAX_CYC;
  // address bytes; erase sends only the three row bytes
  wire [7:0] abyte [5];
  assign abyte[0] = req_reg.col[7:0];
  assign abyte[1] = {3'h0, req_reg.col[12:8]};
  assign abyte[2] = req_reg.row[7:0];
  assign abyte[3] = req_reg.row[15:8];
  assign abyte[4] = {6'h00, req_reg.row[17:16]};
  wire [2:0] asel = aidx_reg + (is_er ? 3'h2 : 3'h0);
  // ==========================================================
  // refusal of an incoming request
  wire in_pg = (req.op == NFC_OP_PROG) || (req.op == NFC_OP_PROG_FIRST) ||
    (req.op == NFC_OP_PROG_LAST);
  // one tracked page, at most four partial programs
  wire pp_full = in_pg && (req.row == pp_page_reg) && (pp_cnt_reg == `NFC_PART_MAX);
  // ecc status only straight after a bare array fetch
  wire ecc_bad = (req.op == NFC_OP_ECC) && !ecc_ok_reg;
  wire refuse = pp_full || ecc_bad;
  // ==========================================================
  // sequencer next state
  always_comb
  begin
    state_next = state_reg;
    pins_next = pins_reg;
    pins_next.wp_n = 1'b1;
    req_next = req_reg;
    ph_next = ph_reg;
    aidx_next = aidx_reg;
    cnt_next = cnt_reg;
    tmr_next = tmr_reg;
    tout_next = tout_reg;
    refd_next = refd_reg;
    lastb_next = lastb_reg;
    take = 1'b0;
    push = 1'b0;
    case (state_reg)
      NFC_S_IDLE:
      begin
        if (req_valid && req_ready_reg)
        begin
          take = 1'b1;
          req_next = req;
          tout_next = 1'b0;
          refd_next = refuse;
          {ph_next, aidx_next, cnt_next, tmr_next} = '0;
          state_next = refuse ? NFC_S_DONE : NFC_S_CMD1;
        end
      end
      NFC_S_CMD1:
      begin
        if (ph_reg == 2'h0)
        begin
          // hold off until the device is ready
          if (rb_sync_reg || !need_ready)
          begin
            pins_next.ce_n = 1'b0;
            pins_next.cle = 1'b1;
            pins_next.io_out = cmd1;
            pins_next.io_oe = 1'b1;
            pins_next.we_n = 1'b0;
            ph_next = 2'h1;
          end
        end
        else
        begin
          pins_next.we_n = 1'b1;
          ph_next = 2'h0;
          state_next = (naddr != 3'h0) ? NFC_S_ADDR : busy_op ? NFC_S_WB : NFC_S_RDATA;
        end
      end
      NFC_S_ADDR:
      begin
        if (ph_reg == 2'h0)
        begin
          pins_next.cle = 1'b0;
          pins_next.ale = 1'b1;
          pins_next.io_out = abyte[asel];
          pins_next.we_n = 1'b0;
          ph_next = 2'h1;
        end
        else
        begin
          pins_next.we_n = 1'b1;
          ph_next = 2'h0;
          aidx_next = aidx_reg + 3'h1;
          if (aidx_reg == naddr - 3'h1)
            state_next = (wr_n != 13'h000) ? NFC_S_WDATA : NFC_S_CMD2;
        end
      end
      NFC_S_WDATA:
      begin
        pins_next.ale = 1'b0;
        if (ph_reg == 2'h0)
        begin
          if (wr_valid && wr_ready_reg)
          begin
            pins_next.io_out = wr_data;
            pins_next.we_n = 1'b0;
            ph_next = 2'h1;
          end
        end
        else
        begin
          pins_next.we_n = 1'b1;
          ph_next = 2'h0;
          cnt_next = cnt_reg + 13'h001;
          if (cnt_reg == wr_n - 13'h001)
            state_next = NFC_S_CMD2;
        end
      end
      NFC_S_CMD2:
      begin
        if (ph_reg == 2'h0)
        begin
          pins_next.ale = 1'b0;
          pins_next.cle = 1'b1;
          pins_next.io_out = cmd2;
          pins_next.we_n = 1'b0;
          ph_next = 2'h1;
        end
        else
        begin
          pins_next.we_n = 1'b1;
          ph_next = 2'h0;
          state_next = NFC_S_WB;
        end
      end
      NFC_S_WB:
      begin
        // busy may lag the we rise; also covers the pin synchroniser
        pins_next.cle = 1'b0;
        pins_next.ale = 1'b0;
        pins_next.io_oe = 1'b0;
        tmr_next = tmr_reg + 16'h0001;
        if (tmr_reg == WB_WAIT)
        begin
          tmr_next = 16'h0000;
          state_next = NFC_S_BUSY;
        end
      end
      NFC_S_BUSY:
      begin
        // wait for ready, give up at the maximum
        if (rb_sync_reg)
          state_next = (rd_n != 13'h000) ? NFC_S_RDATA : NFC_S_DONE;
        else if (tmr_reg == limit)
        begin
          tout_next = 1'b1;
          state_next = NFC_S_DONE;
        end
        else
          tmr_next = tmr_reg + 16'h0001;
      end
      NFC_S_RDATA:
      begin
        // bus released no later than the cycle of the first output strobe fall
        pins_next.cle = 1'b0;
        pins_next.ale = 1'b0;
        pins_next.io_oe = 1'b0;
        case (ph_reg)
          // one strobe per byte; stall while the fifo is full
          2'h0: if (fifo_in_ready)
          begin
            pins_next.output_strobe_n = 1'b0;
            ph_next = 2'h1;
          end
          2'h3:
          begin
            push = 1'b1;
            lastb_next = io_sync_reg;
            pins_next.output_strobe_n = 1'b1;
            ph_next = 2'h0;
            cnt_next = cnt_reg + 13'h001;
            if (cnt_reg == rd_n - 13'h001)
              state_next = NFC_S_DONE;
          end
          default: ph_next = ph_reg + 2'h1;
        endcase
      end
      NFC_S_DONE:
      begin
        // raising ce ends any extended data drive
        pins_next = PINS_RST;
        pins_next.wp_n = 1'b1;
        state_next = NFC_S_IDLE;
      end
      default: state_next = NFC_S_IDLE;
    endcase
  end
  // ==========================================================
  // state registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= NFC_S_IDLE;
      pins_reg <= PINS_RST;
      req_reg <= '0;
      {ph_reg, aidx_reg, cnt_reg, tmr_reg} <= '0;
      {tout_reg, refd_reg, lastb_reg} <= '0;
    end
    else
    begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      req_reg <= req_next;
      {ph_reg, aidx_reg, cnt_reg, tmr_reg} <= {ph_next, aidx_next, cnt_next, tmr_next};
      {tout_reg, refd_reg, lastb_reg} <= {tout_next, refd_next, lastb_next};
    end
  end
  // handshakes and answer, all from flops
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      {req_ready_reg, wr_ready_reg, resp_valid_reg} <= '0;
      resp_reg <= '0;
    end
    else
    begin
      req_ready_reg <= (state_next == NFC_S_IDLE) && !take;
      wr_ready_reg <= (state_next == NFC_S_WDATA) && (ph_next == 2'h0);
      resp_valid_reg <= (state_reg == NFC_S_DONE);
      if (state_reg == NFC_S_DONE)
        resp_reg <= '{refused: refd_reg, timeout: tout_reg, last_byte: lastb_reg};
    end
  end
  // pin synchronisers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      {rb_meta_reg, rb_sync_reg, io_meta_reg, io_sync_reg} <= '0;
    else
      {rb_meta_reg, rb_sync_reg, io_meta_reg, io_sync_reg} <=
        {ready_busy_n, rb_meta_reg, io_in, io_meta_reg};
  end
  // ==========================================================
  // bookkeeping: page program count, ecc window, hung op kind
  wire done_ok = (state_reg == NFC_S_DONE) && !refd_reg && !tout_reg;
  wire blk_hit = (req.row[17:`NFC_BLK_LSB] == pp_page_reg[17:`NFC_BLK_LSB]);
  wire [2:0] pp_cnt_next = (req.row == pp_page_reg) ? pp_cnt_reg + 3'h1 : 3'h1;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      {pp_page_reg, pp_cnt_reg, ecc_ok_reg, hung_reg} <= '0;
    end
    else
    begin
      // count partial programs of the tracked page
      if (take && !refuse && in_pg)
        {pp_page_reg, pp_cnt_reg} <= {req.row, pp_cnt_next};
      else if (take && (req.op == NFC_OP_ERASE) && blk_hit)
        pp_cnt_reg <= 3'h0;
      // window opens after a fetch without data out
      if (take)
        ecc_ok_reg <= 1'b0;
      else if (done_ok && is_rd && (rd_n == 13'h000))
        ecc_ok_reg <= 1'b1;
      // remember a timed out operation for the reset limit
      if ((state_reg == NFC_S_DONE) && tout_reg)
        hung_reg <= is_er ? 2'h2 : is_pg ? 2'h1 : 2'h0;
      else if (done_ok && busy_op)
        hung_reg <= 2'h0;
    end
  end
  // ==========================================================
  // read data buffer; a full fifo stalls the output strobe
  nfc_fifo #(
    .WIDTH(8),
    .DEPTH(8)
  ) u_rd_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_data(io_sync_reg),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(rd_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready)
  );
  assign req_ready = req_ready_reg;
  assign wr_ready = wr_ready_reg;
  assign resp = resp_reg;
  assign resp_valid = resp_valid_reg;
  assign pins = pins_reg;
endmodule : nfc_host

// ### verilog/nfc_pkg.sv
package nfc_pkg;
  // ==========================================================
  // operations the user may request
  typedef enum logic [3:0] {
    NFC_OP_RESET = 4'h0,
    NFC_OP_READ = 4'h1,
    NFC_OP_READ_M = 4'h2,
    NFC_OP_PROG = 4'h3,
    NFC_OP_PROG_FIRST = 4'h4,
    NFC_OP_PROG_LAST = 4'h5,
    NFC_OP_ERASE = 4'h6,
    NFC_OP_STATUS = 4'h7,
    NFC_OP_STATUS_M = 4'h8,
    NFC_OP_ECC = 4'h9
  } nfc_op_t;
  typedef struct packed {
    nfc_op_t op;
    logic [12:0] col;
    logic [17:0] row;
    logic [12:0] len;
  } nfc_req_t;
  typedef struct packed {
    logic refused;
    logic timeout;
    logic [7:0] last_byte;
  } nfc_resp_t;
  // ==========================================================
  // flash pins driven by the controller
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
    logic io_oe;
    logic [7:0] io_out;
  } nfc_pins_t;
  typedef enum logic [8:0] {
    NFC_S_IDLE = 9'h001,
    NFC_S_CMD1 = 9'h002,
    NFC_S_ADDR = 9'h004,
    NFC_S_WDATA = 9'h008,
    NFC_S_CMD2 = 9'h010,
    NFC_S_WB = 9'h020,
    NFC_S_BUSY = 9'h040,
    NFC_S_RDATA = 9'h080,
    NFC_S_DONE = 9'h100
  } nfc_state_t;
endpackage : nfc_pkg

// ### verilog/nfc_regs.svh
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH
// ==========================================================
// command bytes
`define NFC_CMD_READ1 8'h00
`define NFC_CMD_READ2 8'h30
`define NFC_CMD_PROG1 8'h80
`define NFC_CMD_PROGM1 8'h81
`define NFC_CMD_PROG2 8'h10
`define NFC_CMD_PROGMID 8'h11
`define NFC_CMD_ERASE1 8'h60
`define NFC_CMD_ERASE2 8'hd0
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_STATUSM 8'h71
`define NFC_CMD_ECC 8'h7a
`define NFC_CMD_RESET 8'hff
// ==========================================================
// field positions and counts
`define NFC_BLK_LSB 6
`define NFC_PART_MAX 3'h4
`define NFC_ECC_BYTES 13'h008
`define NFC_ADDR_FULL 3'h5
`define NFC_ADDR_ROW 3'h3
// ==========================================================
// times in ns, clock period and derived cycle counts
`define NFC_CLK_NS 100
`define NFC_T_WB_NS 100
`define NFC_T_RST_IDLE_NS 5000
`define NFC_T_RST_PROG_NS 10000
`define NFC_T_RST_ERASE_NS 500000
`define NFC_T_PROG_MAX_NS 700000
`define NFC_T_DCBSY_MAX_NS 1000
`define NFC_T_RD_MAX_NS 220000
`define NFC_T_MRD_MAX_NS 420000
`define NFC_T_ERASE_MAX_NS 5000000
`define NFC_WB_CYC ((`NFC_T_WB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_RST_IDLE_CYC (`NFC_T_RST_IDLE_NS / `NFC_CLK_NS)
`define NFC_RST_PROG_CYC (`NFC_T_RST_PROG_NS / `NFC_CLK_NS)
`define NFC_RST_ERASE_CYC (`NFC_T_RST_ERASE_NS / `NFC_CLK_NS)
`define NFC_PROG_MAX_CYC (`NFC_T_PROG_MAX_NS / `NFC_CLK_NS)
`define NFC_DCBSY_MAX_CYC (`NFC_T_DCBSY_MAX_NS / `NFC_CLK_NS)
`define NFC_RD_MAX_CYC (`NFC_T_RD_MAX_NS / `NFC_CLK_NS)
`define NFC_MRD_MAX_CYC (`NFC_T_MRD_MAX_NS / `NFC_CLK_NS)
`define NFC_ERASE_MAX_CYC (`NFC_T_ERASE_MAX_NS / `NFC_CLK_NS)
`endif
